// File: verif/switch_model.sv
// load switch model whose closed auxiliary follows the close command after a travel delay
`timescale 1ns/100ps
`default_nettype none

module switch_model #(
   parameter int DLY = 3
) (
   input wire logic sys_clk,
   input wire logic cmd,
   output logic aux
);
   logic [DLY-1:0] pipe = '0;
   // contact travel: aux lags the command, so the sequencer must really wait for it
   always_ff @(posedge sys_clk) begin
      pipe <= {pipe[DLY-2:0], cmd};
   end
   assign aux = pipe[DLY-1];
endmodule // switch_model

`default_nettype wire

// File: verif/tb_load_step_and_transfer_control.sv
// self-checking bench for load step and transfer control
`timescale 1ns/100ps
`default_nettype none

module tb_load_step_and_transfer_control;
   logic sys_clk = 0, rst = 1, ce = 1, alt_select = 0, dms_active = 0, fallback_en = 1;
   logic gen_req = 0, stop_seq = 0, in_sync = 0, gen_aux_closed, mains_aux_closed;
   logic [1:0] scheme = 2'h0;
   logic [15:0] gen_power_kw = 16'h0000, sync_ms = 16'h0005;
   logic gen_close_cmd, mains_close_cmd, interlock_override, freq_60hz, on_gen, transfer_busy;
   logic [4:0] dummy_steps, shed_steps;
   load_ctrl_pkg::alt_cfg_s cfg_main, cfg_alt;
   logic [2:0] nsch;
   int miscompares = 0, comparisons = 0, par, ovr;

   load_step_and_transfer_control #(.TICK_CYCLES(4)) i_dut (.sys_clk(sys_clk), .rst(rst),
      .ce(ce), .alt_select(alt_select), .cfg_main(cfg_main), .cfg_alt(cfg_alt),
      .scheme(scheme), .dms_active(dms_active), .fallback_en(fallback_en),
      .sync_timeout_ms(sync_ms), .transfer_ms(16'h0002), .parallel_ms(16'h0003),
      .gen_req(gen_req), .stop_seq(stop_seq), .in_sync(in_sync),
      .gen_aux_closed(gen_aux_closed), .mains_aux_closed(mains_aux_closed),
      .gen_power_kw(gen_power_kw), .gen_close_cmd(gen_close_cmd),
      .mains_close_cmd(mains_close_cmd), .interlock_override(interlock_override),
      .freq_60hz(freq_60hz), .on_gen(on_gen), .transfer_busy(transfer_busy),
      .dummy_steps(dummy_steps), .shed_steps(shed_steps));
   switch_model #(.DLY(2)) i_gen_sw (.sys_clk(sys_clk), .cmd(gen_close_cmd),
      .aux(gen_aux_closed));
   switch_model #(.DLY(7)) i_mains_sw (.sys_clk(sys_clk), .cmd(mains_close_cmd),
      .aux(mains_aux_closed));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [4:0] therm(int n);
      return 5'((1 << n) - 1);
   endfunction

   function automatic load_ctrl_pkg::alt_cfg_s mk(logic f, logic [2:0] n);
      return '{f, '{1'b1, n, 3'h0, 16'h0028, 16'h0064, 16'h0003, 16'h0003},
         '{1'b1, n, 3'h2, 16'h00A0, 16'h008C, 16'h0003, 16'h0003}};
   endfunction

   task automatic check(string name, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // runs one changeover, counting paralleled and override cycles on the way
   task automatic go(logic to_gen);
      logic g0;
      par = 0;
      ovr = 0;
      g0 = gen_close_cmd;
      gen_req <= to_gen;
      for (int i = 0; i < 900; i++) begin
         @(negedge sys_clk);
         if (gen_close_cmd === 1'b1 && mains_close_cmd === 1'b1) par++;
         if (interlock_override === 1'b1) ovr++;
         if (to_gen && gen_close_cmd === 1'b1 && g0 === 1'b0) begin
            check("shed at close", 16'(therm(2)), shed_steps);
            check("dummy at close", 16'h0000, dummy_steps);
         end
         g0 = gen_close_cmd;
         if (i > 3 && transfer_busy === 1'b0) break;
         @(posedge sys_clk);
      end
      check("on gen", 16'(to_gen), on_gen);
      @(posedge sys_clk);
   endtask

   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   initial forever #5 sys_clk = ~sys_clk;

   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      close_out();
   end

   initial begin
      void'($urandom(9));
      nsch = 3'($urandom_range(5, 2));
      cfg_main = mk(1'b0, nsch);
      cfg_alt = mk(1'b1, nsch);
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      check("mains cmd reset", 16'h0001, mains_close_cmd);
      @(posedge sys_clk);
      alt_select <= 1'b1;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      check("freq select", 16'h0001, freq_60hz);
      @(posedge sys_clk);
      alt_select <= 1'b0;
      gen_power_kw <= 16'($urandom_range(39, 0));
      go(1'b1);
      check("open overlap", 16'h0000, 16'(par));
      repeat (300) @(posedge sys_clk);
      @(negedge sys_clk);
      check("dummy up", 16'(therm(nsch)), dummy_steps);
      check("shed down", 16'h0000, shed_steps);
      // short bursts of high load must not add up across a lapse
      for (int k = 0; k < 4; k++) begin
         @(posedge sys_clk);
         gen_power_kw <= k[0] ? 16'h0014 : 16'h03E8;
         repeat (5) @(posedge sys_clk);
      end
      @(negedge sys_clk);
      check("dummy held", 16'(therm(nsch)), dummy_steps);
      @(posedge sys_clk);
      gen_power_kw <= 16'($urandom_range(900, 161));
      repeat (300) @(posedge sys_clk);
      @(negedge sys_clk);
      check("dummy down", 16'h0000, dummy_steps);
      check("shed up", 16'(therm(nsch)), shed_steps);
      @(posedge sys_clk);
      stop_seq <= 1'b1;
      gen_req <= 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      check("stop gen cmd", 16'h0000, gen_close_cmd);
      check("stop steps", 16'h0000, {dummy_steps, shed_steps});
      @(posedge sys_clk);
      stop_seq <= 1'b0;
      go(1'b0);
      scheme <= 2'h2;
      in_sync <= 1'b1;
      go(1'b1);
      check("parallel time", 16'h0001, 16'(par >= 9));
      check("override", 16'h0001, 16'(ovr >= par && par > 0));
      dms_active <= 1'b1;
      go(1'b0);
      check("standby no close", 16'h0000, 16'(par + ovr));
      dms_active <= 1'b0;
      scheme <= 2'h1;
      in_sync <= 1'b0;
      gen_req <= 1'b1;
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      check("sync wait", 16'h0001, mains_close_cmd);
      // clock enable low must freeze the sync timeout as well
      @(posedge sys_clk);
      ce <= 1'b0;
      repeat (40) @(posedge sys_clk);
      ce <= 1'b1;
      @(negedge sys_clk);
      check("frozen sync wait", 16'h0001, mains_close_cmd);
      @(posedge sys_clk);
      go(1'b1);
      check("fallback open", 16'h0000, 16'(par));
      close_out();
   end
endmodule // tb_load_step_and_transfer_control

`default_nettype wire

// File: verilog/load_ctrl_pkg.sv
// shared constants, configuration carriers and state types for load step and transfer control
package load_ctrl_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int TIMER_TICK_MS = 1;
   localparam int TIMER_TICK_CYCLES = (TIMER_TICK_MS * 1000000) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // widths and limits
   // ----------------------------------------------------------------
   localparam int MAX_STEPS = 5;
   localparam int CNT_W = 3;
   localparam int KW_W = 16;
   localparam int MS_W = 16;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0] RST_COUNT = 3'h0;
   localparam logic [MS_W-1:0] RST_MS = 16'h0000;
   localparam logic [31:0] RST_TICK_CNT = 32'h0000_0000;
   localparam logic RST_GEN_CMD = 1'b0;
   localparam logic RST_MAINS_CMD = 1'b1;

   // ----------------------------------------------------------------
   // configuration carriers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      XFER_OPEN = 2'h0,
      XFER_OPEN_SYNC = 2'h1,
      XFER_CLOSED_SYNC = 2'h2
   } xfer_scheme_e;

   typedef struct packed {
      logic enable;
      logic [CNT_W-1:0] outputs_in_scheme;
      logic [CNT_W-1:0] outputs_at_start;
      logic [KW_W-1:0] trip_kw;
      logic [KW_W-1:0] return_kw;
      logic [MS_W-1:0] trip_delay_ms;
      logic [MS_W-1:0] return_delay_ms;
   } step_cfg_s;

   typedef struct packed {
      logic freq_60hz;
      step_cfg_s dummy;
      step_cfg_s shed;
   } alt_cfg_s;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [8:0] {
      ST_ON_MAINS = 9'h001,
      ST_ON_GEN = 9'h002,
      ST_PREP = 9'h004,
      ST_SYNC = 9'h008,
      ST_OPEN_OUT = 9'h010,
      ST_XFER = 9'h020,
      ST_CLOSE_IN = 9'h040,
      ST_PARALLEL = 9'h080,
      ST_OPEN_LAST = 9'h100
   } co_state_e;

   typedef struct packed {
      co_state_e st;
      logic to_gen;
      logic closed_path;
      logic gen_cmd;
      logic mains_cmd;
      logic override;
      logic freq_60hz;
      logic tick;
      logic [MS_W-1:0] ms;
      logic [31:0] tick_cnt;
   } co_reg_s;

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic [MS_W-1:0] up_ms;
      logic [MS_W-1:0] dn_ms;
      logic [MAX_STEPS-1:0] steps;
   } step_reg_s;

endpackage

// File: verilog/load_step_and_transfer_control.sv
// load step control and mains/generator changeover sequencing
// Operation
// RULE_01 - two configuration sets chosen by a selector input, frequency among them
// RULE_02 - dummy load scheme drives at most five steps, count configurable
// RULE_03 - dummy outputs stay off when the generator starts
// RULE_04 - dummy monitoring runs only while the generator carries the load
// RULE_05 - power below dummy trip for full delay adds the next dummy step
// RULE_06 - power above dummy return for full delay removes the highest dummy step
// RULE_07 - stopping drops all steps in the cycle the generator switch opens
// RULE_08 - shedding drives at most five steps, counts in scheme and at start
// RULE_09 - start shedding steps energise before the generator switch closes
// RULE_10 - power above shed trip for full delay adds the next shed step
// RULE_11 - power below shed return for full delay removes the highest shed step
// RULE_12 - open transition: open outgoing, await aux open, transfer time, close incoming
// RULE_13 - sync check variant waits for sync before opening the outgoing switch
// RULE_14 - closed transition: close incoming, await aux, parallel time, open outgoing
// RULE_15 - integrator must wire both closed auxiliary inputs for closed transition
// RULE_16 - with fallback enabled, sync timeout gives an open transition
// RULE_17 - dual mutual standby forbids sync check and closed transition
// RULE_18 - interlock override is driven while switches may be paralleled
// RULE_19 - integrator should wire closed auxiliaries for open transitions too
// RULE_20 - delay timers restart when the condition lapses; one step per expiry
`timescale 1ns/100ps
`default_nettype none

module load_step_and_transfer_control #(
   parameter int unsigned TICK_CYCLES = load_ctrl_pkg::TIMER_TICK_CYCLES,
   parameter int DUMMY_STEPS = load_ctrl_pkg::MAX_STEPS,
   parameter int SHED_STEPS = load_ctrl_pkg::MAX_STEPS
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic alt_select,
   input wire load_ctrl_pkg::alt_cfg_s cfg_main,
   input wire load_ctrl_pkg::alt_cfg_s cfg_alt,
   input wire logic [1:0] scheme,
   input wire logic dms_active,
   input wire logic fallback_en,
   input wire logic [load_ctrl_pkg::MS_W-1:0] sync_timeout_ms,
   input wire logic [load_ctrl_pkg::MS_W-1:0] transfer_ms,
   input wire logic [load_ctrl_pkg::MS_W-1:0] parallel_ms,
   input wire logic gen_req,
   input wire logic stop_seq,
   input wire logic in_sync,
   input wire logic gen_aux_closed,
   input wire logic mains_aux_closed,
   input wire logic [load_ctrl_pkg::KW_W-1:0] gen_power_kw,
   output logic gen_close_cmd,
   output logic mains_close_cmd,
   output logic interlock_override,
   output logic freq_60hz,
   output logic on_gen,
   output logic transfer_busy,
   output logic [DUMMY_STEPS-1:0] dummy_steps,
   output logic [SHED_STEPS-1:0] shed_steps
);

   if (TICK_CYCLES < 1 || TICK_CYCLES > 32'h7FFF_FFFF) begin : g_bad_tick
      $error("load_step_and_transfer_control: TICK_CYCLES out of range");
   end

   // ----------------------------------------------------------------
   // configuration selection
   // ----------------------------------------------------------------
   load_ctrl_pkg::alt_cfg_s cfg;
   logic [1:0] eff_scheme;
   logic path_sync;
   logic path_closed;

   always_comb begin
      cfg = alt_select ? cfg_alt : cfg_main; // RULE_01
      // dual mutual standby leaves only the plain open transition
      eff_scheme = dms_active ? load_ctrl_pkg::XFER_OPEN : scheme; // RULE_17
      path_sync = (eff_scheme == load_ctrl_pkg::XFER_OPEN_SYNC)
         || (eff_scheme == load_ctrl_pkg::XFER_CLOSED_SYNC);
      path_closed = (eff_scheme == load_ctrl_pkg::XFER_CLOSED_SYNC);
   end

   // ----------------------------------------------------------------
   // changeover sequencer
   // ----------------------------------------------------------------
   load_ctrl_pkg::co_reg_s r;
   load_ctrl_pkg::co_reg_s next_r;
   logic out_aux;
   logic in_aux;
   logic drop_loads;
   logic preset_shed;
   logic run_load;

   always_comb begin
      next_r = r;
      next_r.freq_60hz = cfg.freq_60hz; // RULE_01
      // ms tick prescaler shared by every delay
      if (r.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
         next_r.tick_cnt = load_ctrl_pkg::RST_TICK_CNT;
         next_r.tick = 1'b1;
      end else begin
         next_r.tick_cnt = r.tick_cnt + 32'h0000_0001;
         next_r.tick = 1'b0;
      end
      if (r.tick) begin
         next_r.ms = r.ms + 16'h0001;
      end
      out_aux = r.to_gen ? mains_aux_closed : gen_aux_closed;
      in_aux = r.to_gen ? gen_aux_closed : mains_aux_closed;
      case (r.st)
         load_ctrl_pkg::ST_ON_MAINS: begin
            if (gen_req && !stop_seq) begin
               next_r.to_gen = 1'b1;
               next_r.st = load_ctrl_pkg::ST_PREP;
            end
         end
         load_ctrl_pkg::ST_ON_GEN: begin
            if (!gen_req) begin
               next_r.to_gen = 1'b0;
               next_r.st = load_ctrl_pkg::ST_PREP;
            end
         end
         load_ctrl_pkg::ST_PREP: begin
            // shedding preset happens here when heading to the generator, ahead of its close
            next_r.closed_path = path_closed;
            next_r.st = path_sync ? load_ctrl_pkg::ST_SYNC : load_ctrl_pkg::ST_OPEN_OUT;
         end
         load_ctrl_pkg::ST_SYNC: begin
            if (in_sync) begin
               next_r.st = r.closed_path ? load_ctrl_pkg::ST_CLOSE_IN
                  : load_ctrl_pkg::ST_OPEN_OUT; // RULE_13 RULE_14
            end else if (fallback_en && r.ms >= sync_timeout_ms) begin
               next_r.closed_path = 1'b0; // RULE_16
               next_r.st = load_ctrl_pkg::ST_OPEN_OUT;
            end
         end
         load_ctrl_pkg::ST_OPEN_OUT: begin
            if (r.to_gen) begin
               next_r.mains_cmd = 1'b0; // RULE_12
            end else begin
               next_r.gen_cmd = 1'b0;
            end
            // aux feedback is trusted to be wired; a stuck input stalls here
            if (!out_aux) begin
               next_r.st = load_ctrl_pkg::ST_XFER; // RULE_12 RULE_19
            end
         end
         load_ctrl_pkg::ST_XFER: begin
            if (r.ms >= transfer_ms) begin
               next_r.st = load_ctrl_pkg::ST_CLOSE_IN; // RULE_12
            end
         end
         load_ctrl_pkg::ST_CLOSE_IN: begin
            if (r.to_gen) begin
               next_r.gen_cmd = 1'b1;
            end else begin
               next_r.mains_cmd = 1'b1;
            end
            if (in_aux) begin
               if (r.closed_path) begin
                  next_r.st = load_ctrl_pkg::ST_PARALLEL; // RULE_14 RULE_15
               end else begin
                  next_r.st = r.to_gen ? load_ctrl_pkg::ST_ON_GEN : load_ctrl_pkg::ST_ON_MAINS;
               end
            end
         end
         load_ctrl_pkg::ST_PARALLEL: begin
            if (r.ms >= parallel_ms) begin
               next_r.st = load_ctrl_pkg::ST_OPEN_LAST; // RULE_14
            end
         end
         load_ctrl_pkg::ST_OPEN_LAST: begin
            if (r.to_gen) begin
               next_r.mains_cmd = 1'b0; // RULE_14
            end else begin
               next_r.gen_cmd = 1'b0;
            end
            if (!out_aux) begin
               next_r.closed_path = 1'b0;
               next_r.st = r.to_gen ? load_ctrl_pkg::ST_ON_GEN : load_ctrl_pkg::ST_ON_MAINS;
            end
         end
         default: begin
            next_r.st = load_ctrl_pkg::ST_ON_MAINS;
         end
      endcase
      // a stopping sequence opens the generator at once, no sync wait
      if (stop_seq && (r.to_gen || r.gen_cmd || r.st == load_ctrl_pkg::ST_ON_GEN)) begin
         next_r.to_gen = 1'b0;
         next_r.closed_path = 1'b0;
         next_r.gen_cmd = 1'b0; // RULE_07
         next_r.st = load_ctrl_pkg::ST_OPEN_OUT;
      end
      if (next_r.st != r.st) begin
         next_r.ms = load_ctrl_pkg::RST_MS;
      end
      next_r.override = next_r.closed_path && ((next_r.st == load_ctrl_pkg::ST_CLOSE_IN)
         || (next_r.st == load_ctrl_pkg::ST_PARALLEL)
         || (next_r.st == load_ctrl_pkg::ST_OPEN_LAST)); // RULE_18
      // steps fall on the same edge as the generator command
      drop_loads = r.gen_cmd && !next_r.gen_cmd; // RULE_07
      preset_shed = (r.st == load_ctrl_pkg::ST_PREP) && r.to_gen; // RULE_09
      run_load = r.gen_cmd && gen_aux_closed; // RULE_04
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r.st <= load_ctrl_pkg::ST_ON_MAINS;
         r.to_gen <= 1'b0;
         r.closed_path <= 1'b0;
         r.gen_cmd <= load_ctrl_pkg::RST_GEN_CMD;
         r.mains_cmd <= load_ctrl_pkg::RST_MAINS_CMD;
         r.override <= 1'b0;
         r.freq_60hz <= 1'b0;
         r.tick <= 1'b0;
         r.ms <= load_ctrl_pkg::RST_MS;
         r.tick_cnt <= load_ctrl_pkg::RST_TICK_CNT;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign gen_close_cmd = r.gen_cmd;
   assign mains_close_cmd = r.mains_cmd;
   assign interlock_override = r.override;
   assign freq_60hz = r.freq_60hz;
   assign on_gen = (r.st == load_ctrl_pkg::ST_ON_GEN);
   assign transfer_busy = (r.st != load_ctrl_pkg::ST_ON_GEN) && (r.st != load_ctrl_pkg::ST_ON_MAINS);

   // ----------------------------------------------------------------
   // step schemes
   // ----------------------------------------------------------------
   step_scheme #(
      .STEPS(DUMMY_STEPS)
   ) u_dummy (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .tick(r.tick),
      .run(run_load),
      .clear(drop_loads),
      .preset(1'b0),
      .trip_high(1'b0),
      .cfg(cfg.dummy),
      .power_kw(gen_power_kw),
      .steps(dummy_steps)
   );

   step_scheme #(
      .STEPS(SHED_STEPS)
   ) u_shed (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .tick(r.tick),
      .run(run_load),
      .clear(drop_loads),
      .preset(preset_shed),
      .trip_high(1'b1),
      .cfg(cfg.shed),
      .power_kw(gen_power_kw),
      .steps(shed_steps)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_stop_drop: assert property ($fell(gen_close_cmd) // RULE_07
      |-> dummy_steps == '0 && shed_steps == '0)
      else $error("steps still on after generator open");
   chk_stop_open: assert property (ce && stop_seq && gen_close_cmd |=> !gen_close_cmd) // RULE_07
      else $error("stop did not open generator in one cycle");
   chk_dummy_idle: assert property (ce && !run_load && !drop_loads // RULE_04
      && cfg.dummy.enable && $stable(cfg) |=> $stable(dummy_steps))
      else $error("dummy steps moved while off load");
   chk_open_break: assert property ($rose(gen_close_cmd) && !interlock_override // RULE_12
      |-> !mains_close_cmd)
      else $error("open transition closed generator onto mains");
   chk_sync_hold: assert property (ce && r.st == load_ctrl_pkg::ST_SYNC // RULE_13
      && !in_sync && !fallback_en && !stop_seq
      |=> $stable(gen_close_cmd) && $stable(mains_close_cmd))
      else $error("switch moved before sync");
   chk_closed_par: assert property ($fell(mains_close_cmd) && interlock_override // RULE_14
      |-> gen_close_cmd)
      else $error("closed transition opened mains before paralleling");
   chk_fallback_open: assert property (ce && r.st == load_ctrl_pkg::ST_SYNC // RULE_16
      && !in_sync && fallback_en && r.ms >= sync_timeout_ms && !stop_seq
      |=> r.st == load_ctrl_pkg::ST_OPEN_OUT && !r.closed_path)
      else $error("sync timeout did not fall back to open transition");
   chk_dms_nosync: assert property (ce && dms_active // RULE_17
      && r.st == load_ctrl_pkg::ST_PREP
      |=> r.st != load_ctrl_pkg::ST_SYNC ##1 !interlock_override)
      else $error("sync path taken under dual mutual standby");
   chk_override_par: assert property (gen_close_cmd && mains_close_cmd // RULE_18
      |-> interlock_override)
      else $error("both switches closed without interlock override");
   chk_preset_first: assert property ($rose(gen_close_cmd) && cfg.shed.enable // RULE_09
      && cfg.shed.outputs_at_start != 3'h0 && cfg.shed.outputs_in_scheme != 3'h0
      && $stable(cfg) |-> shed_steps[0])
      else $error("start shedding steps not set before close");

   cov_closed_done: cover property (r.st == load_ctrl_pkg::ST_PARALLEL
      ##[1:1000] r.st == load_ctrl_pkg::ST_ON_GEN);
   cov_fallback: cover property (r.st == load_ctrl_pkg::ST_SYNC
      ##1 r.st == load_ctrl_pkg::ST_OPEN_OUT && !in_sync);
   cov_stop: cover property (stop_seq && gen_close_cmd ##1 !gen_close_cmd);
   cov_shed_trip: cover property (on_gen && shed_steps[SHED_STEPS-1]);

endmodule // load_step_and_transfer_control

`default_nettype wire

// File: verilog/step_scheme.sv
// one stepped output scheme: dummy load or load shedding, stepped on power and delay
`timescale 1ns/100ps
`default_nettype none

module step_scheme #(
   parameter int STEPS = load_ctrl_pkg::MAX_STEPS
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic tick,
   input wire logic run,
   input wire logic clear,
   input wire logic preset,
   input wire logic trip_high,
   input wire load_ctrl_pkg::step_cfg_s cfg,
   input wire logic [load_ctrl_pkg::KW_W-1:0] power_kw,
   output logic [STEPS-1:0] steps
);

   if (STEPS < 1 || STEPS > load_ctrl_pkg::MAX_STEPS) begin : g_bad_steps
      $error("step_scheme: STEPS out of range");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [load_ctrl_pkg::CNT_W-1:0] clamp(
      input logic [load_ctrl_pkg::CNT_W-1:0] v,
      input logic [load_ctrl_pkg::CNT_W-1:0] lim);
      return (v > lim) ? lim : v;
   endfunction

   function automatic logic [load_ctrl_pkg::MAX_STEPS-1:0] therm(
      input logic [load_ctrl_pkg::CNT_W-1:0] c);
      logic [load_ctrl_pkg::MAX_STEPS-1:0] t;
      t = '0;
      for (int i = 0; i < load_ctrl_pkg::MAX_STEPS; i++) begin
         t[i] = (i < int'(c));
      end
      return t;
   endfunction

   // ----------------------------------------------------------------
   // stepping
   // ----------------------------------------------------------------
   load_ctrl_pkg::step_reg_s r;
   load_ctrl_pkg::step_reg_s next_r;
   logic [load_ctrl_pkg::CNT_W-1:0] lim;
   logic up_cond;
   logic dn_cond;

   always_comb begin
      next_r = r;
      lim = clamp(cfg.outputs_in_scheme, load_ctrl_pkg::CNT_W'(STEPS)); // RULE_02 RULE_08
      up_cond = trip_high ? (power_kw > cfg.trip_kw) : (power_kw < cfg.trip_kw);
      dn_cond = trip_high ? (power_kw < cfg.return_kw) : (power_kw > cfg.return_kw);
      if (clear || !cfg.enable) begin
         next_r.count = load_ctrl_pkg::RST_COUNT; // RULE_07 RULE_03
         next_r.up_ms = load_ctrl_pkg::RST_MS;
         next_r.dn_ms = load_ctrl_pkg::RST_MS;
      end else if (preset) begin
         next_r.count = clamp(cfg.outputs_at_start, lim); // RULE_09
         next_r.up_ms = load_ctrl_pkg::RST_MS;
         next_r.dn_ms = load_ctrl_pkg::RST_MS;
      end else if (r.count > lim) begin
         next_r.count = lim;
      end else if (!run) begin
         // no monitoring until on load, outputs held
         next_r.up_ms = load_ctrl_pkg::RST_MS; // RULE_04
         next_r.dn_ms = load_ctrl_pkg::RST_MS;
      end else begin
         if (up_cond && r.count < lim) begin
            if (r.up_ms >= cfg.trip_delay_ms) begin
               next_r.count = r.count + 3'h1; // RULE_05 RULE_10
               next_r.up_ms = load_ctrl_pkg::RST_MS; // RULE_20
            end else if (tick) begin
               next_r.up_ms = r.up_ms + 16'h0001;
            end
         end else begin
            next_r.up_ms = load_ctrl_pkg::RST_MS; // RULE_20
         end
         // up step wins a cycle, so at most one step moves per expiry
         if (dn_cond && r.count > 3'h0 && next_r.count == r.count) begin
            if (r.dn_ms >= cfg.return_delay_ms) begin
               next_r.count = r.count - 3'h1; // RULE_06 RULE_11
               next_r.dn_ms = load_ctrl_pkg::RST_MS; // RULE_20
            end else if (tick) begin
               next_r.dn_ms = r.dn_ms + 16'h0001;
            end
         end else begin
            next_r.dn_ms = load_ctrl_pkg::RST_MS; // RULE_20
         end
      end
      next_r.steps = therm(next_r.count);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign steps = r.steps[STEPS-1:0];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_step_limit: assert property (ce |=> r.count <= $past(lim)) // RULE_02
      else $error("step count above configured outputs");
   chk_trip_wait: assert property (ce && !clear && !preset && run && up_cond // RULE_05
      && r.up_ms < cfg.trip_delay_ms |=> r.count <= $past(r.count))
      else $error("step added before trip delay");
   chk_return_wait: assert property (ce && !clear && !preset && run && dn_cond // RULE_06
      && cfg.enable && r.count <= lim
      && r.dn_ms < cfg.return_delay_ms |=> r.count >= $past(r.count))
      else $error("step removed before return delay");
   chk_one_step: assert property (ce && !clear && !preset && cfg.enable // RULE_20
      && $stable(lim) && r.count <= lim
      |=> (r.count == $past(r.count)) || (r.count == $past(r.count) + 3'h1)
      || (r.count == $past(r.count) - 3'h1))
      else $error("more than one step per expiry");

   cov_all_steps: cover property (ce && r.count == lim && lim != 3'h0);

endmodule // step_scheme

`default_nettype wire
